// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dpt_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic              clk_sys;
  logic              nrst;
  logic              wbCyc;
  logic              wbStb;
  logic              wbWe;
  logic [ADDR_W-1:0] wbAdr;
  logic [3:0]        wbSel;
  logic [31:0]       wbDatI;
  logic [31:0]       wbDatO;
  logic              wbAck;
  logic              pin;
  logic              wave;
  logic              irq;
  logic [31:0]       seed;
  logic [31:0]       expV;
  logic [31:0]       expQ[$];
  logic [7:0]        rnd;
  int                fails;
  int                compares;
  int                per;

  dpt_timer_ctrl #(.HS_DIV(1), .LS_DIV(4)) dut (
    .clk_sys         (clk_sys),
    .nrst            (nrst),
    .wb_cyc_i        (wbCyc),
    .wb_stb_i        (wbStb),
    .wb_we_i         (wbWe),
    .wb_adr_i        (wbAdr),
    .wb_sel_i        (wbSel),
    .wb_dat_i        (wbDatI),
    .wb_dat_o        (wbDatO),
    .wb_ack_o        (wbAck),
    .count_input_pin (pin),
    .wave_out_pin    (wave),
    .irq             (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic print_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timeout();
    fails++;
    $display("Error wait expected event seen none");
    print_verdict();
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Request held until ack is sampled, released at that same edge
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= {idx, 2'b00};
    wbDatI <= {24'h00_0000, d};
    wbSel  <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    if (n >= 50) timeout();
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    expQ.push_back({24'h00_0000, e});
    bus(1'b0, idx, 8'h00);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 2000) timeout();
  endtask

  // Second change of the wave output gives one full underflow period
  task automatic gap(output int p);
    logic last;
    int   n;
    last = wave;
    n = 0;
    while (wave === last && n < 40000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 40000) timeout();
    last = wave;
    p = 0;
    while (wave === last && p < 40000) begin
      @(posedge clk_sys);
      p++;
    end
    if (p >= 40000) timeout();
  endtask

  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge clk_sys);
      pin <= 1'b1;
      repeat (hi) @(posedge clk_sys);
      pin <= 1'b0;
      repeat (lo) @(posedge clk_sys);
    end
  endtask

  // ------------------------------------------------------------
  // Read-data checker: oldest note against each read answer
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (wbAck === 1'b1 && wbWe === 1'b0 && wbCyc === 1'b1) begin
      if (expQ.size() == 0) begin
        fails++;
        $display("Error rdata expected none seen %h", wbDatO);
      end else begin
        expV = expQ.pop_front();
        compares++;
        if (wbDatO !== expV) begin
          fails++;
          $display("Error rdata expected %h seen %h", expV, wbDatO);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = '0;
    wbSel = 4'h0;
    wbDatI = 32'h0000_0000;
    pin = 1'b0;
    fails = 0;
    compares = 0;
    seed = 32'h0000_56df;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(IDX_FLAGS, REG_RESET);
    rd(IDX_PAIR, REG_RESET);
    rd(IDX_MODE0, REG_RESET);
    chk("wave", 32'h0000_0000, {31'h0, wave});
    repeat (6) begin
      rnd = xs();
      wr(IDX_PAIR, rnd);
      rd(IDX_PAIR, rnd & PAIR_WMASK);
      rnd = xs();
      wr(IDX_MODE0, rnd);
      rd(IDX_MODE0, rnd & MODE0_WMASK);
    end
    wr(16'hFF40, 8'hFF);
    rd(16'hFF40, 8'h00);
    $display("test registers done");
    // Prescaler codes, high oscillator divides by one here
    wr(IDX_MODE0, 8'h00);
    wr(IDX_PAIR, 8'h05);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MODE0, {3'b000, c[1:0], 3'b001});
      gap(per);
      chk("t0 period ok", 1, (per - (256 << (2 * c))) <= 2 &&
          (256 << (2 * c)) - per <= 2);
    end
    wr(IDX_MODE0, 8'h01);
    wr(IDX_PAIR, 8'h04);
    gap(per);
    chk("t0 slow period ok", 1, per >= 1022 && per <= 1026);
    wr(IDX_MODE0, 8'h00);
    wr(IDX_PAIR, 8'h0E);
    wr(IDX_MODE1, 8'h09);
    rd(IDX_MODE1, 8'h09);
    gap(per);
    chk("t1 period ok", 1, per >= 1022 && per <= 1026);
    wr(IDX_PAIR, 8'h0A);
    repeat (4) @(posedge clk_sys);
    per = 0;
    repeat (1200) begin
      @(posedge clk_sys);
      per += wave;
    end
    chk("wave off", 0, per);
    wr(IDX_MODE1, 8'h00);
    rd(IDX_FLAGS, 8'hC0);
    $display("test prescaler and wave done");
    // Flags, W1C and interrupt
    wr(IDX_PAIR, 8'h01);
    wr(IDX_FLAGS, 8'hC0);
    wr(IDX_IRQ_EN, 8'h40);
    rd(IDX_IRQ_EN, 8'h40);
    wr(IDX_MODE0, 8'h01);
    wait_irq();
    wr(IDX_MODE0, 8'h00);
    rd(IDX_FLAGS, 8'h40);
    rd(IDX_IRQ_STAT, 8'h40);
    wr(IDX_FLAGS, 8'h00);
    rd(IDX_FLAGS, 8'h40);
    wr(IDX_FLAGS, 8'h40);
    rd(IDX_FLAGS, 8'h00);
    chk("irq", 0, irq);
    wr(IDX_MODE0, 8'h01);
    wait_irq();
    wr(IDX_MODE0, 8'h00);
    wr(IDX_IRQ_EN, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk("irq masked", 0, irq);
    wr(IDX_IRQ_CLR, 8'h40);
    rd(IDX_FLAGS, 8'h00);
    repeat (700) @(posedge clk_sys);
    rd(IDX_FLAGS, 8'h00);
    $display("test flags done");
    // Joined width: timer 0 underflow no longer flags
    wr(IDX_PAIR, 8'h11);
    wr(IDX_MODE0, 8'h01);
    repeat (700) @(posedge clk_sys);
    rd(IDX_FLAGS, 8'h00);
    wr(IDX_MODE0, 8'h00);
    wr(IDX_PAIR, 8'h01);
    // Pulse width: counts only while the pin is high
    wr(IDX_MODE0, 8'h61);
    repeat (700) @(posedge clk_sys);
    rd(IDX_FLAGS, 8'h00);
    pin <= 1'b1;
    wr(IDX_IRQ_EN, 8'h40);
    wait_irq();
    rd(IDX_FLAGS, 8'h40);
    pin <= 1'b0;
    wr(IDX_MODE0, 8'h00);
    wr(IDX_FLAGS, 8'h40);
    $display("test width and pulse done");
    // Event counting: short glitches pass only without the rejector
    wr(IDX_MODE0, 8'hE1);
    pulses(300, 2, 6);
    rd(IDX_FLAGS, 8'h00);
    wr(IDX_MODE0, 8'hA1);
    pulses(300, 2, 6);
    rd(IDX_FLAGS, 8'h40);
    wr(IDX_FLAGS, 8'h40);
    wr(IDX_MODE0, 8'h81);
    pulses(300, 2, 6);
    rd(IDX_FLAGS, 8'h40);
    $display("test event done");
    repeat (4) @(posedge clk_sys);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### verilog/dpt_pkg.sv
`default_nettype none
package dpt_pkg;
  // ----------------------------------------------------------------
  // Clock and bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned ADDR_W        = 18;
  localparam int unsigned IDX_W         = 16;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_FLAGS    = 16'hFF25;
  localparam logic [15:0] IDX_PAIR     = 16'hFF30;
  localparam logic [15:0] IDX_MODE0    = 16'hFF31;
  localparam logic [15:0] IDX_MODE1    = 16'hFF32;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hFF50;
  localparam logic [15:0] IDX_IRQ_EN   = 16'hFF51;
  localparam logic [15:0] IDX_IRQ_CLR  = 16'hFF52;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_T1_BIT = 7;
  localparam int unsigned FLAG_T0_BIT = 6;
  localparam int unsigned PAIR_WIDE   = 4;
  localparam int unsigned PAIR_WAVE_OUT_SOURCE_SELECT  = 3;
  localparam int unsigned PAIR_OUTEN  = 2;
  localparam int unsigned PAIR_CK1    = 1;
  localparam int unsigned PAIR_CK0    = 0;
  localparam int unsigned MODE_EVENT  = 7;
  localparam int unsigned MODE_FUNC   = 6;
  localparam int unsigned MODE_POL    = 5;
  localparam int unsigned MODE_DIV_HI = 4;
  localparam int unsigned MODE_DIV_LO = 3;
  localparam int unsigned MODE_RUN    = 0;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] PAIR_WMASK  = 8'h1F;
  localparam logic [7:0] MODE0_WMASK = 8'hFD;
  localparam logic [7:0] MODE1_WMASK = 8'h1D;
  localparam logic [7:0] FLAG_MASK   = 8'hC0;
  localparam logic [7:0] CNT_RELOAD  = 8'hFF;

  // ----------------------------------------------------------------
  // Prescaler ratio codes and their divide masks
  // ----------------------------------------------------------------
  localparam logic [1:0] DIV_64 = 2'b11;
  localparam logic [1:0] DIV_16 = 2'b10;
  localparam logic [1:0] DIV_4  = 2'b01;
  localparam logic [1:0] DIV_1  = 2'b00;
  localparam logic [5:0] MASK_64 = 6'h3F;
  localparam logic [5:0] MASK_16 = 6'h0F;
  localparam logic [5:0] MASK_4  = 6'h03;
  localparam logic [5:0] MASK_1  = 6'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned NR_TIME_NS = 250;
  localparam int unsigned NR_CYCLES  =
    (NR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HS_DIV_DEF = 2;
  localparam int unsigned LS_DIV_DEF = 610;
endpackage
`default_nettype wire

// ### verilog/dpt_presc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dpt_presc_if;
  logic       srcTick;
  logic [1:0] ratio;
  logic       tick;
  modport ctrl  (output srcTick, output ratio, input tick);
  modport presc (input srcTick, input ratio, output tick);
endinterface
`default_nettype wire

// ### verilog/dpt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module dpt_prescaler (
  input  wire logic   clk_sys,
  input  wire logic   nrst,
  dpt_presc_if.presc  pif
);
  import dpt_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } dpt_presc_s;

  dpt_presc_s st_q;
  dpt_presc_s st_d;
  logic [5:0] mask;

  always_comb begin
    unique case (pif.ratio)
      DIV_64: mask = MASK_64;
      DIV_16: mask = MASK_16;
      DIV_4:  mask = MASK_4;
      DIV_1:  mask = MASK_1;
    endcase
  end

  // ----------------------------------------------------------------
  // Divider: one output tick per 2^n source ticks
  // ----------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (pif.srcTick) begin
      if ((st_q.cnt & mask) == mask) begin
        st_d.cnt  = 6'h00;
        st_d.tick = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pif.tick = st_q.tick;

  AST_TICK_CAUSE: assert property (@(posedge clk_sys) disable iff (!nrst)
    pif.tick |-> $past(pif.srcTick))
    else $error("Prescaler tick without a source tick");
endmodule
`default_nettype wire

// ### verilog/dpt_timer_ctrl.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each timer owns a sticky interrupt flag
// - Writing 1 clears flag, 0 keeps it
// - Event-mode bit: 1 event counter, 0 timer
// - Function bit: pulse width or noise rejector
// - Polarity bit picks edge or measured level
// - Prescaler 0 source: high or low oscillator
// - Prescaler 1 source: high or low oscillator
// - Timer 0 ratio 11 gives 64, 10 16
// - Ratio codes give 64, 16, 4, 1
// - Run bit starts and halts timer 0
module dpt_timer_ctrl #(
  parameter int unsigned HS_DIV = dpt_pkg::HS_DIV_DEF,
  parameter int unsigned LS_DIV = dpt_pkg::LS_DIV_DEF
) (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [dpt_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      count_input_pin,
  output logic                           wave_out_pin,
  output logic                           irq
);
  import dpt_pkg::*;

  localparam int unsigned HS_W = $clog2(HS_DIV + 1);
  localparam int unsigned LS_W = $clog2(LS_DIV + 1);
  localparam int unsigned NR_W = $clog2(NR_CYCLES + 1);
  localparam logic [HS_W-1:0] HS_LAST = HS_W'(HS_DIV - 1);
  localparam logic [LS_W-1:0] LS_LAST = LS_W'(LS_DIV - 1);
  localparam logic [NR_W-1:0] NR_LAST = NR_W'(NR_CYCLES - 1);

  typedef struct packed {
    logic            ack;
    logic [7:0]      rdata;
    logic [7:0]      pair;
    logic [7:0]      mode0;
    logic [7:0]      mode1;
    logic [7:0]      flags;
    logic [7:0]      irqEn;
    logic [HS_W-1:0] hsCnt;
    logic [LS_W-1:0] lsCnt;
    logic            hsTick;
    logic            lsTick;
    logic            pinMeta;
    logic            pinSync;
    logic            pinFilt;
    logic            pinPrev;
    logic [NR_W-1:0] nrCnt;
    logic [7:0]      cnt0;
    logic [7:0]      cnt1;
    logic            wave0;
    logic            wave1;
    logic            waveOut;
    logic            irq;
  } dpt_ctl_s;

  dpt_ctl_s st_q;
  dpt_ctl_s st_d;

  // ----------------------------------------------------------------
  // Prescalers, one per timer
  // ----------------------------------------------------------------
  logic [1:0] presTick;

  for (genvar g = 0; g < 2; g++) begin : gPresc
    dpt_presc_if pif ();
    logic ckSel;
    logic [7:0] modeReg;
    assign ckSel   = (g == 0) ? st_q.pair[PAIR_CK0] : st_q.pair[PAIR_CK1];
    assign modeReg = (g == 0) ? st_q.mode0 : st_q.mode1;
    assign pif.srcTick = ckSel ? st_q.hsTick : st_q.lsTick;
    assign pif.ratio   = {modeReg[MODE_DIV_HI], modeReg[MODE_DIV_LO]};
    assign presTick[g] = pif.tick;
    dpt_prescaler uPresc (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .pif     (pif)
    );
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic             aligned;
  logic             wrStrobe;
  logic             rdLane;

  assign idx      = wb_adr_i[ADDR_W-1:2];
  assign aligned  = (wb_adr_i[1:0] == 2'b00);
  // The write lands on the same edge that the master sees ack high
  assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && st_q.ack && aligned
                    && wb_sel_i[0];
  assign rdLane   = aligned;

  // Shared timer events, also watched by the checks below
  logic modeEvent;
  logic modeFunc;
  logic modePol;
  logic run0;
  logic run1;
  logic wide;
  logic level;
  logic edgeHit;
  logic step0;
  logic step1;
  logic under0;
  logic under1;
  logic [7:0] setFlags;
  logic [7:0] clrFlags;

  assign modeEvent = st_q.mode0[MODE_EVENT];
  assign modeFunc  = st_q.mode0[MODE_FUNC];
  assign modePol   = st_q.mode0[MODE_POL];
  assign run0      = st_q.mode0[MODE_RUN];
  assign run1      = st_q.mode1[MODE_RUN];
  assign wide      = st_q.pair[PAIR_WIDE];

  // In event mode the rejector output is used only when it is enabled
  assign level   = (modeEvent && modeFunc) ? st_q.pinFilt : st_q.pinSync;
  assign edgeHit = modePol ? (level && !st_q.pinPrev)
                           : (!level && st_q.pinPrev);

  always_comb begin
    if (modeEvent) begin
      step0 = run0 && edgeHit;
    end else if (modeFunc) begin
      // Pulse width: count only while the pin sits at the chosen level
      step0 = run0 && presTick[0] && (st_q.pinSync == modePol);
    end else begin
      step0 = run0 && presTick[0];
    end
  end

  assign under0 = step0 && (st_q.cnt0 == 8'h00);
  assign step1  = wide ? under0 : (run1 && presTick[1]);
  assign under1 = step1 && (st_q.cnt1 == 8'h00);

  // A joined pair raises only the upper timer's flag
  assign setFlags = {under1, under0 && !wide, 6'h00};
  assign clrFlags = (wrStrobe && (idx == IDX_FLAGS || idx == IDX_IRQ_CLR))
                    ? (wb_dat_i[7:0] & FLAG_MASK) : 8'h00;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // Oscillator enables derived from the single system clock
    st_d.hsTick = (st_q.hsCnt == HS_LAST);
    st_d.hsCnt  = st_d.hsTick ? '0 : st_q.hsCnt + HS_W'(1);
    st_d.lsTick = (st_q.lsCnt == LS_LAST);
    st_d.lsCnt  = st_d.lsTick ? '0 : st_q.lsCnt + LS_W'(1);

    // Pin synchroniser, then noise rejector
    st_d.pinMeta = count_input_pin;
    st_d.pinSync = st_q.pinMeta;
    if (st_q.pinSync == st_q.pinFilt) begin
      st_d.nrCnt = '0;
    end else if (st_q.nrCnt == NR_LAST) begin
      st_d.nrCnt   = '0;
      st_d.pinFilt = st_q.pinSync;
    end else begin
      st_d.nrCnt = st_q.nrCnt + NR_W'(1);
    end
    st_d.pinPrev = level;

    // Down counters
    if (step0) begin
      st_d.cnt0 = under0 ? CNT_RELOAD : st_q.cnt0 - 8'h01;
    end
    if (step1) begin
      st_d.cnt1 = under1 ? CNT_RELOAD : st_q.cnt1 - 8'h01;
    end

    // Square wave toggles on each underflow of its timer
    st_d.wave0   = st_q.wave0 ^ under0;
    st_d.wave1   = st_q.wave1 ^ under1;
    st_d.waveOut = st_q.pair[PAIR_OUTEN]
                   && (st_q.pair[PAIR_WAVE_OUT_SOURCE_SELECT] ? st_q.wave1 : st_q.wave0);

    // Flags: a new event beats a clear in the same cycle
    st_d.flags = (st_q.flags & ~clrFlags) | setFlags;

    // Wishbone classic: ack one cycle after the request, for one cycle
    st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
    if (wb_cyc_i && wb_stb_i && !st_q.ack) begin
      st_d.rdata = 8'h00;
      if (rdLane) begin
        unique case (idx)
          IDX_FLAGS:    st_d.rdata = st_q.flags;
          IDX_PAIR:     st_d.rdata = st_q.pair;
          IDX_MODE0:    st_d.rdata = st_q.mode0;
          IDX_MODE1:    st_d.rdata = st_q.mode1;
          IDX_IRQ_STAT: st_d.rdata = st_q.flags;
          IDX_IRQ_EN:   st_d.rdata = st_q.irqEn;
          default:      st_d.rdata = 8'h00;
        endcase
      end
    end
    if (wrStrobe) begin
      unique case (idx)
        IDX_PAIR:   st_d.pair  = wb_dat_i[7:0] & PAIR_WMASK;
        IDX_MODE0:  st_d.mode0 = wb_dat_i[7:0] & MODE0_WMASK;
        IDX_MODE1:  st_d.mode1 = wb_dat_i[7:0] & MODE1_WMASK;
        IDX_IRQ_EN: st_d.irqEn = wb_dat_i[7:0] & FLAG_MASK;
        default:    st_d.rdata = st_q.rdata;
      endcase
    end

    st_d.irq = |(st_d.flags & st_d.irqEn);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q       <= '0;
      st_q.cnt0  <= CNT_RELOAD;
      st_q.cnt1  <= CNT_RELOAD;
      st_q.pair  <= REG_RESET;
      st_q.mode0 <= REG_RESET;
      st_q.flags <= REG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o     = {24'h00_0000, st_q.rdata};
  assign wb_ack_o     = st_q.ack;
  assign wave_out_pin = st_q.waveOut;
  assign irq          = st_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FLAG_SETS: assert property (@(posedge clk_sys) disable iff (!nrst)
    (under0 && !wide) |=> st_q.flags[FLAG_T0_BIT])
    else $error("Timer 0 underflow did not set its flag");

  AST_FLAG_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clrFlags[FLAG_T1_BIT] && !under1) |=> !st_q.flags[FLAG_T1_BIT])
    else $error("Writing one did not clear the timer 1 flag");

  AST_FLAG_KEEPS: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wrStrobe && idx == IDX_FLAGS && !wb_dat_i[FLAG_T0_BIT])
    |=> st_q.flags[FLAG_T0_BIT] == ($past(st_q.flags[FLAG_T0_BIT])
        || $past(under0 && !wide)))
    else $error("Writing zero changed the timer 0 flag");

  AST_MODE_RESET: assert property (@(posedge clk_sys)
    !nrst |=> (st_q.mode0 == 8'h00) && (st_q.pair == 8'h00))
    else $error("Control registers not zero after reset");

  AST_EVENT_EDGE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (modeEvent && run0 && !modeFunc && $rose(st_q.pinSync) && modePol
     && st_q.pinPrev == 1'b0 && st_q.cnt0 != 8'h00)
    |=> st_q.cnt0 == $past(st_q.cnt0) - 8'h01)
    else $error("Rising edge did not decrement timer 0");

  AST_PW_GATE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!modeEvent && modeFunc && st_q.pinSync != modePol)
    |=> $stable(st_q.cnt0))
    else $error("Pulse width timer counted at the wrong level");

  AST_STOPPED: assert property (@(posedge clk_sys) disable iff (!nrst)
    !run0 [*2] |=> $stable(st_q.cnt0))
    else $error("Timer 0 counted while stopped");

  // Ratio 1 makes the prescaler transparent, so its tick shows the source
  AST_SRC_SEL: assert property (@(posedge clk_sys) disable iff (!nrst)
    (gPresc[0].pif.ratio == DIV_1 && !st_q.pair[PAIR_CK0])
    |=> presTick[0] == $past(st_q.lsTick))
    else $error("Prescaler 0 fed from the wrong oscillator");

  AST_WIDE_CHAIN: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wide && !under0) |=> $stable(st_q.cnt1))
    else $error("Joined upper timer moved without a lower underflow");

  AST_WAVE_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_q.pair[PAIR_OUTEN] |=> !wave_out_pin)
    else $error("Wave output active while disabled");

  AST_WAVE_T0: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q.pair[PAIR_OUTEN] && !st_q.pair[PAIR_WAVE_OUT_SOURCE_SELECT])
    |=> wave_out_pin == $past(st_q.wave0))
    else $error("Wave output does not follow timer 0");

  AST_WAVE_T1: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q.pair[PAIR_OUTEN] && st_q.pair[PAIR_WAVE_OUT_SOURCE_SELECT])
    |=> wave_out_pin == $past(st_q.wave1))
    else $error("Wave output does not follow timer 1");

  AST_T1_FLAG_SETS: assert property (@(posedge clk_sys) disable iff (!nrst)
    under1 |=> st_q.flags[FLAG_T1_BIT])
    else $error("Timer 1 underflow did not set its flag");

  // A joined pair must never raise the lower flag, or software would
  // see two interrupts for one 16-bit wrap
  AST_WIDE_NO_T0: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wide && !st_q.flags[FLAG_T0_BIT]) |=> !st_q.flags[FLAG_T0_BIT])
    else $error("Joined pair raised the timer 0 flag");

  AST_RUN_COUNTS: assert property (@(posedge clk_sys) disable iff (!nrst)
    (run0 && !modeEvent && !modeFunc && presTick[0] && st_q.cnt0 != 8'h00)
    |=> st_q.cnt0 == $past(st_q.cnt0) - 8'h01)
    else $error("Running timer 0 missed a prescaler tick");

  AST_PW_COUNT: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!modeEvent && modeFunc && run0 && presTick[0]
     && st_q.pinSync == modePol && st_q.cnt0 != 8'h00)
    |=> st_q.cnt0 == $past(st_q.cnt0) - 8'h01)
    else $error("Pulse width timer missed a tick at the chosen level");

  AST_FALL_EDGE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (modeEvent && run0 && !modeFunc && !modePol && $fell(st_q.pinSync)
     && st_q.pinPrev && st_q.cnt0 != 8'h00)
    |=> st_q.cnt0 == $past(st_q.cnt0) - 8'h01)
    else $error("Falling edge did not decrement timer 0");

  // The rejector trades about five cycles of latency for glitch immunity
  AST_NR_HOLDS: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q.pinSync != st_q.pinFilt && st_q.nrCnt != NR_LAST)
    |=> $stable(st_q.pinFilt))
    else $error("Noise rejector passed a short pulse");

  AST_MODE_WRITE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wrStrobe && idx == IDX_MODE0)
    |=> st_q.mode0 == ($past(wb_dat_i[7:0]) & MODE0_WMASK))
    else $error("Timer 0 mode write did not land");

  AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq == |(st_q.flags & st_q.irqEn))
    else $error("Interrupt output does not match enabled flags");
endmodule
`default_nettype wire
